// file: hdl/exec_unit.sv
// execution unit for increment-skip, subtract, nibble swap and fill instructions
`include "exec_regs.svh"
`default_nettype none
module exec_unit (
  input wire logic clock,
  input wire logic reset,
  input wire exec_pkg::instr_t instr,
  output logic [7:0] acc,
  output exec_pkg::result_t res
);
  import exec_pkg::*;

  state_t state;
  state_t next_state;
  // carry out of bit 7 is dropped: ff plus one must read as zero for the skip test
  logic [8:0] sum;

  function automatic logic [7:0] minus(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, ~b} + 9'h001;
    return s[7:0];
  endfunction

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.res = '0;
    sum = {1'b0, instr.mem_data} + 9'h001;
    unique case (state.phase)
      st_dummy: begin
        // the prefetched word is thrown away here; whatever arrives is ignored
        next_state.phase = st_run;
        next_state.res.done = 1'b1;
      end
      st_run: begin
        if (instr.valid) begin
          next_state.res.done = 1'b1;
          unique case (instr.op)
            `OP_INC_SKIP: begin
              next_state.res.mem_we = 1'b1;
              next_state.res.mem_wdata = sum[7:0];
              if (sum[7:0] == 8'h00) begin
                next_state.res.skip = 1'b1;
                next_state.res.done = 1'b0;
                next_state.phase = st_dummy;
              end
            end
            `OP_INC_ACC_SKIP: begin
              next_state.acc = sum[7:0];
              if (sum[7:0] == 8'h00) begin
                next_state.res.skip = 1'b1;
                next_state.res.done = 1'b0;
                next_state.phase = st_dummy;
              end
            end
            `OP_SUB_ACC: next_state.acc = minus(state.acc, instr.mem_data);
            `OP_SUB_MEM: begin
              next_state.res.mem_we = 1'b1;
              next_state.res.mem_wdata = minus(state.acc, instr.mem_data);
            end
            `OP_SUB_IMM: next_state.acc = minus(state.acc, instr.imm);
            `OP_SWAP_MEM: begin
              next_state.res.mem_we = 1'b1;
              next_state.res.mem_wdata = swap_nib(instr.mem_data);
            end
            `OP_SWAP_ACC: next_state.acc = swap_nib(instr.mem_data);
            `OP_FILL: begin
              next_state.res.mem_we = 1'b1;
              next_state.res.mem_wdata = `FILL_VALUE;
            end
            `OP_SET_BIT: begin
              next_state.res.mem_we = 1'b1;
              next_state.res.mem_wdata = instr.mem_data | (8'h01 << instr.bit_sel);
            end
            // opcodes owned by neighbouring units still retire in one cycle
            default: next_state.res.done = 1'b1;
          endcase
        end
      end
      default: next_state.phase = st_run;
    endcase
  end

  // reset also drops a pending dummy cycle, so the first word after reset is always taken
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state.phase <= st_run;
      state.acc <= `ACC_RESET;
      state.res <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign acc = state.acc;
  assign res = state.res;

  ////////////////////////////////////////////////////////////////////////////
  sequence inc_zero_s;
    instr.valid && state.phase == st_run && instr.op == `OP_INC_SKIP && instr.mem_data == 8'hff;
  endsequence

  sequence acc_zero_s;
    instr.valid && state.phase == st_run && instr.op == `OP_INC_ACC_SKIP && instr.mem_data == 8'hff;
  endsequence

  sequence mem_skip_s;
    res.skip && !res.done && res.mem_we && res.mem_wdata == 8'h00;
  endsequence

  sequence acc_skip_s;
    res.skip && !res.done && !res.mem_we && acc == 8'h00;
  endsequence

  sequence dummy_s;
    res.done && !res.skip && !res.mem_we;
  endsequence

  inc_skip_two_a: assert property (@(posedge clock) disable iff (reset)
    inc_zero_s |=> mem_skip_s ##1 dummy_s)
    else $error("increment skip did not take two cycles");

  inc_noskip_one_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_INC_SKIP && instr.mem_data != 8'hff
    |=> res.done && !res.skip && res.mem_we && res.mem_wdata == $past(instr.mem_data) + 8'h01)
    else $error("increment without skip wrong");

  inc_acc_skip_a: assert property (@(posedge clock) disable iff (reset)
    acc_zero_s |=> acc_skip_s ##1 dummy_s)
    else $error("increment to accumulator skip wrong");

  inc_acc_noskip_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_INC_ACC_SKIP && instr.mem_data != 8'hff
    |=> res.done && !res.skip && !res.mem_we && acc == $past(instr.mem_data) + 8'h01)
    else $error("increment to accumulator without skip wrong");

  sub_acc_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_SUB_ACC
    |=> acc == $past(acc) - $past(instr.mem_data) && !res.mem_we)
    else $error("subtract to accumulator wrong");

  sub_mem_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_SUB_MEM
    |=> res.mem_we && res.mem_wdata == $past(acc) - $past(instr.mem_data) && $stable(acc))
    else $error("subtract to memory wrong");

  sub_imm_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_SUB_IMM
    |=> acc == $past(acc) - $past(instr.imm) && !res.mem_we)
    else $error("immediate subtract wrong");

  swap_mem_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_SWAP_MEM
    |=> res.mem_we && res.mem_wdata[3:0] == $past(instr.mem_data[7:4]) && res.mem_wdata[7:4] == $past(instr.mem_data[3:0]))
    else $error("nibble swap in memory wrong");

  swap_acc_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_SWAP_ACC
    |=> !res.mem_we && acc[3:0] == $past(instr.mem_data[7:4]) && acc[7:4] == $past(instr.mem_data[3:0]))
    else $error("nibble swap to accumulator wrong");

  fill_mem_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_FILL |=> res.mem_we && res.mem_wdata == 8'hff)
    else $error("memory fill wrong");

  set_bit_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && instr.op == `OP_SET_BIT
    |=> res.mem_we && res.mem_wdata[$past(instr.bit_sel)] && (res.mem_wdata | $past(instr.mem_data)) == res.mem_wdata
    && res.mem_wdata == ($past(instr.mem_data) | (8'h01 << $past(instr.bit_sel))))
    else $error("bit set wrong");

  ////////////////////////////////////////////////////////////////////////////
  // the dummy cycle, the skip flag and the ops that must leave one side alone
  dummy_drop_a: assert property (@(posedge clock) disable iff (reset)
    state.phase == st_dummy |=> dummy_s)
    else $error("word offered in the dummy cycle was not dropped");

  dummy_acc_a: assert property (@(posedge clock) disable iff (reset)
    state.phase == st_dummy |=> $stable(acc))
    else $error("accumulator changed in the dummy cycle");

  skip_zero_a: assert property (@(posedge clock) disable iff (reset)
    res.skip
    |-> (res.mem_we && res.mem_wdata == 8'h00) || (!res.mem_we && acc == 8'h00))
    else $error("skip raised on a nonzero result");

  skip_source_a: assert property (@(posedge clock) disable iff (reset)
    res.skip |-> $past(instr.valid)
    && ($past(instr.op) == `OP_INC_SKIP || $past(instr.op) == `OP_INC_ACC_SKIP))
    else $error("skip raised by an instruction that cannot skip");

  mem_kept_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && (instr.op == `OP_INC_ACC_SKIP || instr.op == `OP_SUB_ACC
    || instr.op == `OP_SUB_IMM || instr.op == `OP_SWAP_ACC)
    |=> !res.mem_we)
    else $error("memory written by an accumulator instruction");

  acc_kept_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && (instr.op == `OP_SUB_MEM || instr.op == `OP_SWAP_MEM
    || instr.op == `OP_FILL || instr.op == `OP_SET_BIT || instr.op == `OP_INC_SKIP)
    |=> $stable(acc))
    else $error("accumulator changed by a memory instruction");

  unknown_op_a: assert property (@(posedge clock) disable iff (reset)
    instr.valid && state.phase == st_run && (instr.op == `OP_NOP || instr.op > `OP_SET_BIT)
    |=> res.done && !res.skip && !res.mem_we && $stable(acc))
    else $error("foreign opcode did more than retire");

  idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
    !instr.valid && state.phase == st_run
    |=> !res.done && !res.skip && !res.mem_we && $stable(acc))
    else $error("activity without a valid instruction");
endmodule
`default_nettype wire

// file: inc/exec_regs.svh
// constants for the increment, subtract, swap and fill execution block
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
`define OP_NOP 4'h0
`define OP_INC_SKIP 4'h1
`define OP_INC_ACC_SKIP 4'h2
`define OP_SUB_ACC 4'h3
`define OP_SUB_MEM 4'h4
`define OP_SUB_IMM 4'h5
`define OP_SWAP_MEM 4'h6
`define OP_SWAP_ACC 4'h7
`define OP_FILL 4'h8
`define OP_SET_BIT 4'h9
`define ACC_RESET 8'h00
`define FILL_VALUE 8'hff
`endif

// file: inc/exec_pkg.sv
// types for the execution block
package exec_pkg;
  typedef struct packed {
    logic valid;
    logic [3:0] op;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } instr_t;
  typedef struct packed {
    logic mem_we;
    logic [7:0] mem_wdata;
    logic skip;
    logic done;
  } result_t;
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_dummy = 2'b01
  } phase_t;
  typedef struct packed {
    phase_t phase;
    logic [7:0] acc;
    result_t res;
  } state_t;
endpackage

// file: testbench/exec_unit_tb.sv
// self-checking bench for the execution unit
`include "exec_regs.svh"
`default_nettype none
module exec_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  typedef struct {logic [3:0] op; logic [7:0] m, imm; logic [2:0] b; logic [7:0] acc; logic we; logic [7:0] wd;} row_t;
  logic clock;
  logic reset;
  instr_t instr;
  logic [7:0] acc;
  result_t res;
  int n_fail;
  int check_count;
  // acc carries over from row to row, so the order of rows matters
  row_t rows[15] = '{
    '{`OP_SUB_IMM, 8'h00, 8'h05, 3'h0, 8'hfb, 1'h0, 8'h00},
    '{`OP_SUB_ACC, 8'h10, 8'h00, 3'h0, 8'heb, 1'h0, 8'h00},
    '{`OP_SUB_MEM, 8'hf0, 8'h00, 3'h0, 8'heb, 1'h1, 8'hfb},
    '{`OP_SWAP_MEM, 8'h3c, 8'h00, 3'h0, 8'heb, 1'h1, 8'hc3},
    '{`OP_SWAP_ACC, 8'ha5, 8'h00, 3'h0, 8'h5a, 1'h0, 8'h00},
    '{`OP_FILL, 8'h12, 8'h00, 3'h0, 8'h5a, 1'h1, `FILL_VALUE},
    '{`OP_SET_BIT, 8'h00, 8'h00, 3'h7, 8'h5a, 1'h1, 8'h80},
    '{`OP_SET_BIT, 8'h7e, 8'h00, 3'h0, 8'h5a, 1'h1, 8'h7f},
    '{`OP_INC_SKIP, 8'h41, 8'h00, 3'h0, 8'h5a, 1'h1, 8'h42},
    '{`OP_INC_ACC_SKIP, 8'h7f, 8'h00, 3'h0, 8'h80, 1'h0, 8'h00},
    '{`OP_SUB_ACC, 8'h80, 8'h00, 3'h0, 8'h00, 1'h0, 8'h00},
    '{`OP_SUB_IMM, 8'h00, 8'h01, 3'h0, 8'hff, 1'h0, 8'h00},
    '{`OP_SET_BIT, 8'ha5, 8'h00, 3'h3, 8'hff, 1'h1, 8'had},
    '{`OP_NOP, 8'h55, 8'h33, 3'h2, 8'hff, 1'h0, 8'h00},
    '{4'hf, 8'h55, 8'h33, 3'h2, 8'hff, 1'h0, 8'h00}};

  exec_unit exec_unit_inst (.clock(clock), .reset(reset), .instr(instr), .acc(acc), .res(res));

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // flags are {mem_we, skip, done}
  task automatic check_flags(input logic [2:0] exp);
    check("flags", {5'h00, res.mem_we, res.skip, res.done}, {5'h00, exp});
  endtask

  task automatic put(input logic [3:0] op, input logic [7:0] m, input logic [7:0] imm);
    instr = '{1'h1, op, m, imm, 3'h0};
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 100 cycles
  initial begin
    #(1000 * 20);
    n_fail++;
    report_and_stop();
  end

  initial begin
    reset = 1'h1;
    instr = '0;
    repeat (4) @(negedge clock);
    check("acc", acc, `ACC_RESET);
    check_flags(3'h0);
    reset = 1'h0;
    $display("test reset done");
    ////////////////////////////////////////////////////////////////
    for (int i = 0; i < 15; i++) begin
      instr = '{1'h1, rows[i].op, rows[i].m, rows[i].imm, rows[i].b};
      @(negedge clock);
      check("acc", acc, rows[i].acc);
      check_flags({rows[i].we, 2'h1});
      if (rows[i].we) check("wdata", res.mem_wdata, rows[i].wd);
    end
    $display("test rows done");
    ////////////////////////////////////////////////////////////////
    // the instruction offered during the dummy cycle must vanish
    put(`OP_INC_SKIP, 8'hff, 8'h00);
    @(negedge clock);
    check_flags(3'h6);
    check("wdata", res.mem_wdata, 8'h00);
    put(`OP_SUB_IMM, 8'h00, 8'h01);
    @(negedge clock);
    check_flags(3'h1);
    check("acc", acc, 8'hff);
    put(`OP_INC_ACC_SKIP, 8'hff, 8'h00);
    @(negedge clock);
    check_flags(3'h2);
    check("acc", acc, 8'h00);
    put(`OP_FILL, 8'h00, 8'h00);
    @(negedge clock);
    check_flags(3'h1);
    put(`OP_SUB_IMM, 8'h00, 8'h01);
    @(negedge clock);
    check("acc", acc, 8'hff);
    check_flags(3'h1);
    instr = '0;
    @(negedge clock);
    check_flags(3'h0);
    $display("test skip done");
    ////////////////////////////////////////////////////////////////
    // reset in the middle of a skip must also drop the pending dummy cycle
    put(`OP_INC_SKIP, 8'hff, 8'h00);
    @(negedge clock);
    check_flags(3'h6);
    reset = 1'h1;
    #1;
    check("acc", acc, `ACC_RESET);
    check_flags(3'h0);
    @(negedge clock);
    reset = 1'h0;
    put(`OP_SUB_IMM, 8'h00, 8'h02);
    @(negedge clock);
    check("acc", acc, 8'hfe);
    check_flags(3'h1);
    instr = '0;
    @(negedge clock);
    check_flags(3'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
